// *** design/usb_phy_control_regs.sv ***
// usb power signalling and phy control registers with suspend controller and interrupts
//
// Behaviour
// - bit 18 set disables both wide-port pulldowns
// - auto-resume on se0 sets sticky bit 13
// - auto-resume on k state sets bit 12
// - line change passes after 2^n stable cycles
// - bit 7 lets hardware handle suspend resume
// - bits 6:4 drive phy configuration pins directly
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "usb_phy_cfg.svh"

module usb_phy_control_regs (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// usb line side
	input wire logic [1:0] line_state_in,
	input wire logic suspend_in,
	// phy and port controls
	output logic pulldown_dis_out,
	output logic [2:0] phy_config_pins_out,
	output logic [1:0] line_filt_out,
	output logic resume_out,
	// power signalling
	output logic [7:0] power_data_out,
	output logic power_valid_out,
	// interrupt
	output logic irq_out
);

	usb_phy_pkg::phy_ctrl_t phy;
	usb_phy_pkg::phy_ctrl_t next_phy;
	usb_phy_pkg::pwr_sig_t pwr;
	usb_phy_pkg::pwr_sig_t next_pwr;
	usb_phy_pkg::wake_state_t state;
	usb_phy_pkg::wake_state_t next_state;
	logic [2:0] stat;
	logic [2:0] next_stat;
	logic [2:0] mask;
	logic [2:0] next_mask;
	logic [31:0] next_rdata;
	logic next_irq;
	logic next_resume;
	logic line_chg;
	logic wake_se0;
	logic wake_k;

	// address decode for writes; reads decode the address in a case statement
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// pack the phy control fields into a bus word, reserved bits zero
	function automatic logic [31:0] phy_word(input usb_phy_pkg::phy_ctrl_t p);
		logic [31:0] w;
		w = `RESET_WORD;
		w[`PHY_PD_DIS_BIT] = p.pd_dis;
		w[`PHY_SE0_BIT] = p.se0_flag;
		w[`PHY_K_BIT] = p.k_flag;
		w[`PHY_FILT_HI:`PHY_FILT_LO] = p.filt_log2;
		w[`PHY_AUTO_BIT] = p.auto_en;
		w[`PHY_CONF_HI:`PHY_CONF_LO] = p.conf;
		return w;
	endfunction

	// pack the power signalling fields into a bus word
	function automatic logic [31:0] pwr_word(input usb_phy_pkg::pwr_sig_t p);
		logic [31:0] w;
		w = `RESET_WORD;
		w[`PWR_VALID_BIT] = p.valid;
		w[`PWR_DATA_HI:`PWR_DATA_LO] = p.data;
		return w;
	endfunction

	// settle filter on the raw line state
	line_filter #(
		.CNT_W(16)
	) u_filter (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.line_raw_in(line_state_in),
		.log2_in(phy.filt_log2),
		.line_filt_out(line_filt_out),
		.change_out(line_chg)
	);

	// suspend controller: only watches the filtered line, so glitches shorter than the 2^n-cycle settle time cannot wake it
	always_comb begin
		next_state = state;
		wake_se0 = 1'b0;
		wake_k = 1'b0;
		case (state)
			usb_phy_pkg::ST_AWAKE: begin
				if (phy.auto_en && suspend_in) begin
					next_state = usb_phy_pkg::ST_ASLEEP;
				end
			end
			usb_phy_pkg::ST_ASLEEP: begin
				if (!phy.auto_en) begin
					next_state = usb_phy_pkg::ST_AWAKE;
				end else if (line_filt_out == `LS_SE0) begin
					wake_se0 = 1'b1;
					next_state = usb_phy_pkg::ST_WOKEN;
				end else if (line_filt_out == `LS_K) begin
					wake_k = 1'b1;
					next_state = usb_phy_pkg::ST_WOKEN;
				end
			end
			usb_phy_pkg::ST_WOKEN: begin
				if (!phy.auto_en || !suspend_in) begin
					next_state = usb_phy_pkg::ST_AWAKE;
				end
			end
			default: begin
				next_state = usb_phy_pkg::ST_AWAKE;
			end
		endcase
		next_resume = (next_state == usb_phy_pkg::ST_WOKEN);
	end

	// register file; hardware sets are applied last so they win over clears
	always_comb begin
		next_phy = phy;
		next_pwr = pwr;
		next_mask = mask;
		next_stat = stat;
		next_rdata = `RESET_WORD;
		if (wr_in) begin
			if (hit(addr_in, `OFF_PWR_SIG)) begin
				next_pwr.valid = wdata_in[`PWR_VALID_BIT];
				next_pwr.data = wdata_in[`PWR_DATA_HI:`PWR_DATA_LO];
			end
			if (hit(addr_in, `OFF_PHY_CTRL)) begin
				next_phy.pd_dis = wdata_in[`PHY_PD_DIS_BIT];
				next_phy.filt_log2 = wdata_in[`PHY_FILT_HI:`PHY_FILT_LO];
				next_phy.auto_en = wdata_in[`PHY_AUTO_BIT];
				next_phy.conf = wdata_in[`PHY_CONF_HI:`PHY_CONF_LO];
				// flags clear on zero; a one leaves them alone so rmw is safe
				next_phy.se0_flag = phy.se0_flag & wdata_in[`PHY_SE0_BIT];
				next_phy.k_flag = phy.k_flag & wdata_in[`PHY_K_BIT];
			end
			if (hit(addr_in, `OFF_IRQ_MASK)) begin
				next_mask = wdata_in[2:0];
			end
		end
		if (rd_in) begin
			case (addr_in)
				`OFF_PWR_SIG: next_rdata = pwr_word(pwr);
				`OFF_PHY_CTRL: next_rdata = phy_word(phy);
				`OFF_IRQ_STAT: begin
					next_rdata = {29'h000_0000, stat};
					next_stat = 3'h0;
				end
				`OFF_IRQ_MASK: next_rdata = {29'h000_0000, mask};
				`OFF_LINE_STAT: begin
					next_rdata[`LINE_FILT_HI:`LINE_FILT_LO] = line_filt_out;
					next_rdata[`LINE_ASLEEP_BIT] = (state == usb_phy_pkg::ST_ASLEEP);
				end
				default: next_rdata = `RESET_WORD;
			endcase
		end
		if (wake_se0) begin
			next_phy.se0_flag = 1'b1;
			next_stat[`IRQ_SE0_BIT] = 1'b1;
		end
		if (wake_k) begin
			next_phy.k_flag = 1'b1;
			next_stat[`IRQ_K_BIT] = 1'b1;
		end
		if (line_chg) begin
			next_stat[`IRQ_CHG_BIT] = 1'b1;
		end
		// level interrupt computed from next values so it tracks status exactly
		next_irq = |(next_stat & next_mask);
	end

	// state registers; outputs mirror flip-flops only
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			phy <= '0;
			pwr <= '0;
			mask <= 3'h0;
			stat <= 3'h0;
			state <= usb_phy_pkg::ST_AWAKE;
			rdata_out <= `RESET_WORD;
			irq_out <= 1'b0;
			resume_out <= 1'b0;
		end else begin
			phy <= next_phy;
			pwr <= next_pwr;
			mask <= next_mask;
			stat <= next_stat;
			state <= next_state;
			rdata_out <= next_rdata;
			irq_out <= next_irq;
			resume_out <= next_resume;
		end
	end

	// control outputs taken straight from the register fields
	assign pulldown_dis_out = phy.pd_dis;
	assign phy_config_pins_out = phy.conf;
	assign power_data_out = pwr.data;
	assign power_valid_out = pwr.valid;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// a write to the phy register moves the pulldown control next cycle
	property p_pulldown;
		(wr_in && addr_in == `OFF_PHY_CTRL)
			|=> (pulldown_dis_out == $past(wdata_in[`PHY_PD_DIS_BIT]));
	endproperty
	a_pulldown: assert property (p_pulldown) else $error("pulldown control not updated");

	// sleeping with se0 on the filtered line
	sequence s_wake_se0;
		state == usb_phy_pkg::ST_ASLEEP && phy.auto_en && line_filt_out == `LS_SE0;
	endsequence

	property p_se0_flag;
		s_wake_se0 |=> phy.se0_flag && resume_out;
	endproperty
	a_se0_flag: assert property (p_se0_flag) else $error("se0 wake not flagged");

	// the se0 flag only falls when software writes zero to it
	property p_se0_hold;
		$fell(phy.se0_flag) |-> $past(wr_in) && ($past(addr_in) == `OFF_PHY_CTRL)
			&& !$past(wdata_in[`PHY_SE0_BIT]);
	endproperty
	a_se0_hold: assert property (p_se0_hold) else $error("se0 flag cleared by itself");

	// sleeping with k on the filtered line
	property p_k_flag;
		(state == usb_phy_pkg::ST_ASLEEP && phy.auto_en && line_filt_out == `LS_K)
			|=> phy.k_flag && resume_out;
	endproperty
	a_k_flag: assert property (p_k_flag) else $error("k wake not flagged");

	// the k flag only falls when software writes zero to it
	property p_k_hold;
		$fell(phy.k_flag) |-> $past(wr_in) && ($past(addr_in) == `OFF_PHY_CTRL)
			&& !$past(wdata_in[`PHY_K_BIT]);
	endproperty
	a_k_hold: assert property (p_k_hold) else $error("k flag cleared by itself");

	// without auto resume the controller drops out and never signals a resume;
	// every state falls back to awake, so one cycle is enough to see it
	property p_no_auto;
		!phy.auto_en |=> !resume_out && (state == usb_phy_pkg::ST_AWAKE);
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("resume raised without auto mode");

	// configuration pins follow the written field one cycle on
	property p_conf;
		(wr_in && addr_in == `OFF_PHY_CTRL)
			|=> (phy_config_pins_out == $past(wdata_in[`PHY_CONF_HI:`PHY_CONF_LO]));
	endproperty
	a_conf: assert property (p_conf) else $error("config pins not updated");

	// reserved bits of the phy register always read as zero
	property p_reserved;
		(rd_in && addr_in == `OFF_PHY_CTRL) |=> ((rdata_out & ~`PHY_RMASK) == 32'h0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

	// reserved bits of the power register always read as zero
	property p_reserved_pwr;
		(rd_in && addr_in == `OFF_PWR_SIG) |=> ((rdata_out & ~`PWR_RMASK) == 32'h0);
	endproperty
	a_reserved_pwr: assert property (p_reserved_pwr) else $error("power reserved bits nonzero");

	// a masked-in line change raises the interrupt on the next edge, even under a status read
	property p_irq;
		(line_chg && mask[`IRQ_CHG_BIT] && !(wr_in && addr_in == `OFF_IRQ_MASK)) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	// a status read with no new event drops the interrupt on the next edge
	property p_irq_clear;
		(rd_in && addr_in == `OFF_IRQ_STAT && !line_chg && !wake_se0 && !wake_k) |=> !irq_out;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt kept after status read");

endmodule // usb_phy_control_regs

// *** design/usb_phy_cfg.svh ***
// register offsets, field positions, reset values and line codes of the usb phy control block
`ifndef USB_PHY_CFG_SVH
`define USB_PHY_CFG_SVH

// byte offsets on the register port
`define OFF_PWR_SIG 8'h3c
`define OFF_PHY_CTRL 8'h40
`define OFF_IRQ_STAT 8'h44
`define OFF_IRQ_MASK 8'h48
`define OFF_LINE_STAT 8'h4c

// power signalling fields
`define PWR_VALID_BIT 8
`define PWR_DATA_HI 7
`define PWR_DATA_LO 0

// phy control fields
`define PHY_PD_DIS_BIT 18
`define PHY_SE0_BIT 13
`define PHY_K_BIT 12
`define PHY_FILT_HI 11
`define PHY_FILT_LO 8
`define PHY_AUTO_BIT 7
`define PHY_CONF_HI 6
`define PHY_CONF_LO 4

// interrupt status and mask fields
`define IRQ_SE0_BIT 0
`define IRQ_K_BIT 1
`define IRQ_CHG_BIT 2

// line status fields
`define LINE_FILT_HI 1
`define LINE_FILT_LO 0
`define LINE_ASLEEP_BIT 2

// reset values and readable masks
`define RESET_WORD 32'h0000_0000
`define PWR_RMASK 32'h0000_01ff
`define PHY_RMASK 32'h0004_3ff0

// usb line state codes
`define LS_SE0 2'h0
`define LS_J 2'h1
`define LS_K 2'h2

`endif

// *** design/usb_phy_pkg.sv ***
// types shared by the usb phy control block
package usb_phy_pkg;

	// phy control register contents
	typedef struct packed {
		logic pd_dis;
		logic se0_flag;
		logic k_flag;
		logic [3:0] filt_log2;
		logic auto_en;
		logic [2:0] conf;
	} phy_ctrl_t;

	// power signalling register contents
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} pwr_sig_t;

	// suspend controller states
	typedef enum logic [2:0] {
		ST_AWAKE = 3'b001,
		ST_ASLEEP = 3'b010,
		ST_WOKEN = 3'b100
	} wake_state_t;

endpackage

// *** design/line_filter.sv ***
// glitch filter for the usb line state with a power-of-two settle time
`timescale 1ns/1ns
`include "usb_phy_cfg.svh"

module line_filter #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// raw line and settle exponent
	input wire logic [1:0] line_raw_in,
	input wire logic [3:0] log2_in,
	// filtered line
	output logic [1:0] line_filt_out,
	output logic change_out
);

	logic [1:0] cand;
	logic [1:0] next_cand;
	logic [1:0] next_filt;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] target;
	logic next_change;

	// settle time in cycles is two to the programmed exponent
	assign target = {{(CNT_W-1){1'b0}}, 1'b1} << log2_in;

	// count cycles the candidate has held; any new value restarts the count
	always_comb begin
		next_cand = cand;
		next_cnt = cnt;
		next_filt = line_filt_out;
		next_change = 1'b0;
		if (line_raw_in == line_filt_out) begin
			next_cand = line_filt_out;
			next_cnt = '0;
		end else if (line_raw_in != cand) begin
			next_cand = line_raw_in;
			next_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
		end else begin
			next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		if (next_cand != line_filt_out && next_cnt >= target) begin
			next_filt = next_cand;
			next_change = 1'b1;
			next_cnt = '0;
		end
	end

	// state registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cand <= `LS_SE0;
			cnt <= '0;
			line_filt_out <= `LS_SE0;
			change_out <= 1'b0;
		end else begin
			cand <= next_cand;
			cnt <= next_cnt;
			line_filt_out <= next_filt;
			change_out <= next_change;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// the filtered line never moves without its change pulse
	property p_filt_pulse;
		(line_filt_out != $past(line_filt_out)) |-> change_out;
	endproperty
	a_filt_pulse: assert property (p_filt_pulse) else $error("filtered line moved silently");

	// with exponent zero a new raw value passes after one cycle
	property p_filt_fast;
		(log2_in == 4'h0 && line_raw_in != line_filt_out) |=> (line_filt_out == $past(line_raw_in));
	endproperty
	a_filt_fast: assert property (p_filt_fast) else $error("unfiltered change not passed");

	// with exponent two a change needs four stable cycles
	property p_filt_slow;
		(log2_in == 4'h2 && $stable(log2_in) && line_raw_in != line_filt_out
			&& line_raw_in != $past(line_raw_in)) |=> (line_filt_out == $past(line_filt_out));
	endproperty
	a_filt_slow: assert property (p_filt_slow) else $error("filter passed a change too early");

endmodule // line_filter

// *** verif/usb_line_model.sv ***
// usb bus model: line state and suspend seen by the phy block
`timescale 1ns/1ns

module usb_line_model (
	// clock
	input wire logic clk_in,
	// line side toward the block
	output logic [1:0] line_out,
	output logic suspend_out
);

	// the bus idles in j, awake
	initial begin
		line_out = 2'h1;
		suspend_out = 1'b0;
	end

	// hold a line state for n cycles; changes land just after an edge
	task put(input logic [1:0] v, input int n);
		@(posedge clk_in);
		line_out <= v;
		repeat (n - 1) @(posedge clk_in);
		// step off the edge so callers read settled outputs
		#1;
	endtask

	// host suspends or wakes the bus; the suspend level holds until the next call
	task sus(input logic b);
		@(posedge clk_in);
		suspend_out <= b;
	endtask

endmodule // usb_line_model

// *** verif/test_usb_phy_control_regs.sv ***
// self-checking bench for the usb phy control registers
`timescale 1ns/1ns
`include "usb_phy_cfg.svh"

module test_usb_phy_control_regs;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [1:0] line;
	logic susp;
	logic pd_dis;
	logic [2:0] conf;
	logic [1:0] filt;
	logic resume;
	logic [7:0] pdata;
	logic pvalid;
	logic irq;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	// 25 MHz core clock
	always #20 clk_in = ~clk_in;

	usb_phy_control_regs u_dut (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.addr_in(addr),
		.wdata_in(wdata),
		.wr_in(wr),
		.rd_in(rd),
		.rdata_out(rdata),
		.line_state_in(line),
		.suspend_in(susp),
		.pulldown_dis_out(pd_dis),
		.phy_config_pins_out(conf),
		.line_filt_out(filt),
		.resume_out(resume),
		.power_data_out(pdata),
		.power_valid_out(pvalid),
		.irq_out(irq)
	);

	usb_line_model u_line (
		.clk_in(clk_in),
		.line_out(line),
		.suspend_out(susp)
	);

	task wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// a hang is cut short well beyond the roughly 140 cycles needed
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task rreg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		rreg(`OFF_PWR_SIG, 32'h0000_0000);
		rreg(`OFF_PHY_CTRL, 32'h0000_0000);
		wreg(`OFF_PWR_SIG, 32'hffff_ffff);
		rreg(`OFF_PWR_SIG, 32'h0000_01ff);
		chk({23'h0, pvalid, pdata}, 32'h0000_01ff);
		wreg(`OFF_PHY_CTRL, 32'hffff_ffff);
		rreg(`OFF_PHY_CTRL, 32'h0004_0ff0);
		chk({31'h0, pd_dis}, 32'h0000_0001);
		chk({29'h0, conf}, 32'h0000_0007);
		// filter of four cycles; a two-cycle k glitch is dropped
		wreg(`OFF_PHY_CTRL, 32'h0000_0200);
		tick(1);
		chk({28'h0, pd_dis, conf}, 32'h0000_0000);
		u_line.put(`LS_K, 2);
		u_line.put(`LS_J, 8);
		chk({30'h0, filt}, 32'h0000_0001);
		// three k samples so far: still j; the fourth sample passes it
		u_line.put(`LS_K, 4);
		chk({30'h0, filt}, 32'h0000_0001);
		tick(1);
		chk({30'h0, filt}, 32'h0000_0002);
		// hardware resume on k with every interrupt unmasked
		wreg(`OFF_IRQ_MASK, 32'h0000_0007);
		u_line.put(`LS_J, 8);
		rreg(`OFF_IRQ_STAT, 32'h0000_0004);
		wreg(`OFF_PHY_CTRL, 32'h0000_0080);
		u_line.sus(1'b1);
		u_line.put(`LS_K, 4);
		chk({30'h0, resume, irq}, 32'h0000_0003);
		rreg(`OFF_PHY_CTRL, 32'h0000_1080);
		rreg(`OFF_IRQ_STAT, 32'h0000_0006);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0000);
		wreg(`OFF_PHY_CTRL, 32'h0000_0080);
		rreg(`OFF_PHY_CTRL, 32'h0000_0080);
		u_line.sus(1'b0);
		tick(3);
		chk({31'h0, resume}, 32'h0000_0000);
		// hardware resume on se0
		u_line.put(`LS_J, 8);
		rreg(`OFF_IRQ_STAT, 32'h0000_0004);
		u_line.sus(1'b1);
		u_line.put(`LS_SE0, 4);
		rreg(`OFF_PHY_CTRL, 32'h0000_2080);
		rreg(`OFF_IRQ_STAT, 32'h0000_0005);
		u_line.sus(1'b0);
		wreg(`OFF_PHY_CTRL, 32'h0000_0000);
		// auto mode off: no wake, changes only reach status, masked out
		wreg(`OFF_IRQ_MASK, 32'h0000_0000);
		u_line.put(`LS_J, 8);
		u_line.sus(1'b1);
		u_line.put(`LS_K, 8);
		chk({30'h0, resume, irq}, 32'h0000_0000);
		rreg(`OFF_PHY_CTRL, 32'h0000_0000);
		rreg(`OFF_LINE_STAT, 32'h0000_0002);
		wreg(`OFF_IRQ_MASK, 32'h0000_0004);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0001);
		rreg(`OFF_IRQ_STAT, 32'h0000_0004);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0000);
		rreg(8'h50, 32'h0000_0000);
		wrap_up;
	end

endmodule // test_usb_phy_control_regs
